// *** rtl/iscr_defines.svh ***
`ifndef ISCR_DEFINES_SVH
`define ISCR_DEFINES_SVH

// Register word addresses on the plain register port.
`define ISCR_REG_DATA       2'h0
`define ISCR_REG_ADDR       2'h1
`define ISCR_REG_MODE       2'h2
`define ISCR_REG_STAT       2'h3

// Reset values of the registers.
`define ISCR_DATA_RST       8'h00
`define ISCR_ADDR_RST       8'h00
`define ISCR_MODE_RST       8'hE0
`define ISCR_STAT_RST       8'h81

// Operating mode codes of the three-bit mode field.
`define ISCR_OP_SPI_M4      3'h0
`define ISCR_OP_SPI_M16     3'h1
`define ISCR_OP_SPI_M64     3'h2
`define ISCR_OP_SPI_MSUB    3'h3
`define ISCR_OP_SPI_MTMR    3'h4
`define ISCR_OP_SPI_SLAVE   3'h5
`define ISCR_OP_I2C_SLAVE   3'h6
`define ISCR_OP_NONE        3'h7

// Debounce select codes and their filter lengths in system clocks.
`define ISCR_DEB_OFF        2'h0
`define ISCR_DEB_SEL_SHORT  2'h1
`define ISCR_DEB_SHORT      2
`define ISCR_DEB_LONG       4

// Bits in a byte, and bit counter value at the end of a byte.
`define ISCR_BYTE_BITS      4'h8

`endif

// *** rtl/iscr_pkg.sv ***
package iscr_pkg;

   // Bus-side states of the slave engine.
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_HOLD,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_WAIT_STOP
   } iscr_state_t;

   // Conditions seen on the two bus lines in one system clock.
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } iscr_evt_t;

   // Layout of the unit mode control register.
   typedef struct packed {
      logic [2:0] op;
      logic       rsvd;
      logic [1:0] deb;
      logic       en;
      logic       icf;
   } iscr_mode_t;

   // Layout of the bus status control register.
   typedef struct packed {
      logic transfer_complete_flag;
      logic address_match_flag;
      logic busy;
      logic dir;
      logic transmit_ack_bit;
      logic master_read_write_flag;
      logic wake_en;
      logic receive_ack_flag;
   } iscr_stat_t;

endpackage

// *** rtl/iscr_top.sv ***
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "iscr_defines.svh"
// Summary of operation
// - One 8-bit data buffer holds bytes to send and bytes received.
// - Own address sits in bits 7..1; bit 0 is plain read/write storage.
// - Slave is selected when the called 7-bit address equals the own address.
// - Mode field codes select SPI modes, I2C slave (110) or none; reset 111.
// - Debounce select 00 none, 01 two clocks, 1x four clocks on SCL.
// - Enable low releases the pins and idles the unit; enable high operates the unit only in I2C slave mode (110).
// - Enable rising in I2C mode resets status flags, keeps direction and ack bit.
// - Completion flag is 0 during a byte, 1 after it with an event; resets 1.
// - Address match flag shows whether the last calling address matched.
// - Busy flag sets on START and clears on STOP.
// - Direction bit 0 makes the slave receive, 1 makes it transmit.
// - On the ninth clock after a received byte the ack bit is driven on SDA.
// - The master read/write bit is captured into a read-only flag.
// - With wake enable set, an address match raises a wake-up request.
// - Receive ack flag holds SDA sampled on the ninth clock; resets 1.
// - Transmitter keeps sending while acked, else releases SDA for STOP.
// - Mode bit 0 has no I2C role; mode bit 4 reads zero.
// - A matching address is answered with a low ack on the ninth bit.
module iscr_top #(
   parameter int DEB_SHORT = `ISCR_DEB_SHORT,
   parameter int DEB_LONG  = `ISCR_DEB_LONG
) (
   input  wire logic       CLK_IN,
   input  wire logic       RESET_IN,
   input  wire logic       CE_IN,
   input  wire logic [1:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_RD_IN,
   output logic      [7:0] REG_RDATA_OUT,
   input  wire logic       SCL_IN,
   output logic            SCL_OUT,
   output logic            SCL_OE_N_OUT,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N_OUT,
   output logic            PIN_FUNC_OUT,
   output logic            XFER_EVENT_OUT,
   output logic            WAKEUP_OUT
);

   // Filter lengths must fit the four-bit debounce counter.
   if (DEB_SHORT < 1 || DEB_LONG < 1 || DEB_SHORT > 15 || DEB_LONG > 15) begin : g_chk
      $error("Debounce lengths must lie between 1 and 15.");
   end

   iscr_pkg::iscr_mode_t  mode_ff;
   iscr_pkg::iscr_stat_t  stat_ff;
   iscr_pkg::iscr_state_t state_ff;
   iscr_pkg::iscr_evt_t   evt;
   logic [7:0] data_ff;
   logic [7:0] own_addr_ff;
   logic [7:0] rdata_ff;
   logic [7:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic [3:0] deb_cnt_ff;
   logic [3:0] deb_need;
   logic       scl_s1_ff;
   logic       scl_s2_ff;
   logic       scl_s3_ff;
   logic       sda_s1_ff;
   logic       sda_s2_ff;
   logic       sda_s3_ff;
   logic       scl_lvl_ff;
   logic       sda_lvl_ff;
   logic       scl_filt_ff;
   logic       scl_prev_ff;
   logic       sda_prev_ff;
   logic       sda_drv_ff;
   logic       scl_hold_ff;
   logic       en_prev_ff;
   logic       event_ff;
   logic       wake_ff;
   logic       active;
   logic       en_rise;
   logic       addr_match;
   logic       byte_end;
   logic       byte_done;
   logic       data_wr;
   logic       data_rd;

   // The unit works only when enabled and set to I2C slave mode.
   assign active  = mode_ff.en && (mode_ff.op == `ISCR_OP_I2C_SLAVE);
   assign en_rise = mode_ff.en && !en_prev_ff && (mode_ff.op == `ISCR_OP_I2C_SLAVE);
   assign data_wr = REG_WR_IN && (REG_ADDR_IN == `ISCR_REG_DATA);
   assign data_rd = REG_RD_IN && (REG_ADDR_IN == `ISCR_REG_DATA);

   // Three-stage synchronisers; a level is accepted once stages two and three agree.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         scl_s1_ff  <= 1'b1;
         scl_s2_ff  <= 1'b1;
         scl_s3_ff  <= 1'b1;
         sda_s1_ff  <= 1'b1;
         sda_s2_ff  <= 1'b1;
         sda_s3_ff  <= 1'b1;
         scl_lvl_ff <= 1'b1;
         sda_lvl_ff <= 1'b1;
      end else if (CE_IN) begin
         scl_s1_ff <= SCL_IN;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= SDA_IN;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
         if (scl_s2_ff == scl_s3_ff) begin
            scl_lvl_ff <= scl_s3_ff;
         end
         if (sda_s2_ff == sda_s3_ff) begin
            sda_lvl_ff <= sda_s3_ff;
         end
      end
   end

   // Number of consecutive differing samples needed before SCL is accepted.
   always_comb begin
      case (mode_ff.deb)
         `ISCR_DEB_OFF:       deb_need = 4'h0;
         `ISCR_DEB_SEL_SHORT: deb_need = DEB_SHORT[3:0];
         default:             deb_need = DEB_LONG[3:0];
      endcase
   end

   // SCL debounce filter: a new level must persist for the chosen length.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         scl_filt_ff <= 1'b1;
         deb_cnt_ff  <= 4'h0;
      end else if (CE_IN) begin
         if (scl_lvl_ff == scl_filt_ff) begin
            deb_cnt_ff <= 4'h0;
         end else if (deb_cnt_ff + 4'h1 >= deb_need) begin
            scl_filt_ff <= scl_lvl_ff;
            deb_cnt_ff  <= 4'h0;
         end else begin
            deb_cnt_ff <= deb_cnt_ff + 4'h1;
         end
      end
   end

   // Previous line levels for edge and condition detection.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         en_prev_ff  <= 1'b0;
      end else if (CE_IN) begin
         scl_prev_ff <= scl_filt_ff;
         sda_prev_ff <= sda_lvl_ff;
         en_prev_ff  <= mode_ff.en;
      end
   end

   // Bus conditions; START and STOP need SCL high both raw and filtered.
   always_comb begin
      evt.rise  = active && scl_filt_ff && !scl_prev_ff;
      evt.fall  = active && !scl_filt_ff && scl_prev_ff;
      evt.start = active && scl_filt_ff && scl_lvl_ff && sda_prev_ff && !sda_lvl_ff;
      evt.stop  = active && scl_filt_ff && scl_lvl_ff && !sda_prev_ff && sda_lvl_ff;
   end

   assign addr_match = (shift_ff[7:1] == own_addr_ff[7:1]);
   assign byte_end   = evt.fall && (bit_cnt_ff == `ISCR_BYTE_BITS) && !evt.start && !evt.stop;
   assign byte_done  = byte_end && ((state_ff == iscr_pkg::ST_ADDR && addr_match) ||
                                    state_ff == iscr_pkg::ST_RX || state_ff == iscr_pkg::ST_TX);

   // Slave engine: address phase, byte shifting, acknowledges and clock holding.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN || (CE_IN && !active)) begin
         state_ff    <= iscr_pkg::ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         shift_ff    <= 8'h00;
         sda_drv_ff  <= 1'b0;
         scl_hold_ff <= 1'b0;
      end else if (CE_IN) begin
         if (evt.stop) begin
            state_ff    <= iscr_pkg::ST_IDLE;
            sda_drv_ff  <= 1'b0;
            scl_hold_ff <= 1'b0;
         end else if (evt.start) begin
            state_ff    <= iscr_pkg::ST_ADDR;
            bit_cnt_ff  <= 4'h0;
            sda_drv_ff  <= 1'b0;
            scl_hold_ff <= 1'b0;
         end else begin
            case (state_ff)
               iscr_pkg::ST_ADDR: begin
                  if (evt.rise) begin
                     shift_ff   <= {shift_ff[6:0], sda_lvl_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (byte_end && addr_match) begin
                     state_ff   <= iscr_pkg::ST_ADDR_ACK;
                     sda_drv_ff <= 1'b1;
                  end else if (byte_end) begin
                     state_ff <= iscr_pkg::ST_WAIT_STOP;
                  end
               end
               iscr_pkg::ST_ADDR_ACK: begin
                  if (evt.fall) begin
                     sda_drv_ff  <= 1'b0;
                     scl_hold_ff <= 1'b1;
                     state_ff    <= iscr_pkg::ST_HOLD;
                  end
               end
               iscr_pkg::ST_HOLD: begin
                  if (stat_ff.dir && data_wr) begin
                     shift_ff    <= REG_WDATA_IN;
                     sda_drv_ff  <= !REG_WDATA_IN[7];
                     bit_cnt_ff  <= 4'h0;
                     scl_hold_ff <= 1'b0;
                     state_ff    <= iscr_pkg::ST_TX;
                  end else if (!stat_ff.dir && data_rd) begin
                     bit_cnt_ff  <= 4'h0;
                     scl_hold_ff <= 1'b0;
                     state_ff    <= iscr_pkg::ST_RX;
                  end
               end
               iscr_pkg::ST_RX: begin
                  if (evt.rise) begin
                     shift_ff   <= {shift_ff[6:0], sda_lvl_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (byte_end) begin
                     sda_drv_ff <= !stat_ff.transmit_ack_bit;
                     state_ff   <= iscr_pkg::ST_RX_ACK;
                  end
               end
               iscr_pkg::ST_RX_ACK: begin
                  if (evt.fall) begin
                     sda_drv_ff  <= 1'b0;
                     scl_hold_ff <= 1'b1;
                     state_ff    <= iscr_pkg::ST_HOLD;
                  end
               end
               iscr_pkg::ST_TX: begin
                  if (evt.rise) begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (byte_end) begin
                     sda_drv_ff <= 1'b0;
                     state_ff   <= iscr_pkg::ST_TX_ACK;
                  end else if (evt.fall) begin
                     shift_ff   <= {shift_ff[6:0], 1'b0};
                     sda_drv_ff <= !shift_ff[6];
                  end
               end
               iscr_pkg::ST_TX_ACK: begin
                  if (evt.fall && !stat_ff.receive_ack_flag) begin
                     scl_hold_ff <= 1'b1;
                     state_ff    <= iscr_pkg::ST_HOLD;
                  end else if (evt.fall) begin
                     state_ff <= iscr_pkg::ST_WAIT_STOP;
                  end
               end
               iscr_pkg::ST_WAIT_STOP: begin
                  sda_drv_ff <= 1'b0;
               end
               default: begin
                  state_ff <= iscr_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Status flags; software writes reach only dir, ack bit and wake enable, which no hardware event changes.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         stat_ff <= `ISCR_STAT_RST;
      end else if (CE_IN) begin
         // Software bits take a write even in the cycle of an enable rise.
         if (REG_WR_IN && REG_ADDR_IN == `ISCR_REG_STAT) begin
            stat_ff.dir     <= REG_WDATA_IN[4];
            stat_ff.transmit_ack_bit    <= REG_WDATA_IN[3];
            stat_ff.wake_en <= REG_WDATA_IN[1];
         end
         if (en_rise) begin
            stat_ff.transfer_complete_flag  <= 1'b1;
            stat_ff.address_match_flag <= 1'b0;
            stat_ff.busy <= 1'b0;
            stat_ff.master_read_write_flag  <= 1'b0;
            stat_ff.receive_ack_flag <= 1'b1;
         end else begin
            if (evt.start) begin
               stat_ff.busy <= 1'b1;
            end else if (evt.stop) begin
               stat_ff.busy <= 1'b0;
            end
            if (byte_done) begin
               stat_ff.transfer_complete_flag <= 1'b1;
            end else if (evt.start || (state_ff == iscr_pkg::ST_HOLD &&
                         ((stat_ff.dir && data_wr) || (!stat_ff.dir && data_rd)))) begin
               stat_ff.transfer_complete_flag <= 1'b0;
            end
            if (byte_end && state_ff == iscr_pkg::ST_ADDR) begin
               stat_ff.address_match_flag <= addr_match;
               if (addr_match) begin
                  stat_ff.master_read_write_flag <= shift_ff[0];
               end
            end
            if (state_ff == iscr_pkg::ST_TX_ACK && evt.rise) begin
               stat_ff.receive_ack_flag <= sda_lvl_ff;
            end
         end
      end
   end

   // Configuration registers and the shared data buffer.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         mode_ff     <= `ISCR_MODE_RST;
         own_addr_ff <= `ISCR_ADDR_RST;
         data_ff     <= `ISCR_DATA_RST;
      end else if (CE_IN) begin
         if (REG_WR_IN && REG_ADDR_IN == `ISCR_REG_MODE) begin
            mode_ff      <= REG_WDATA_IN;
            mode_ff.rsvd <= 1'b0;
         end
         if (REG_WR_IN && REG_ADDR_IN == `ISCR_REG_ADDR) begin
            own_addr_ff <= REG_WDATA_IN;
         end
         if (byte_done && state_ff == iscr_pkg::ST_RX) begin
            data_ff <= shift_ff;
         end else if (data_wr) begin
            data_ff <= REG_WDATA_IN;
         end
      end
   end

   // Read data, valid in the cycle after the read strobe.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         rdata_ff <= 8'h00;
      end else if (CE_IN && REG_RD_IN) begin
         case (REG_ADDR_IN)
            `ISCR_REG_DATA: rdata_ff <= data_ff;
            `ISCR_REG_ADDR: rdata_ff <= own_addr_ff;
            `ISCR_REG_MODE: rdata_ff <= mode_ff;
            default:        rdata_ff <= stat_ff;
         endcase
      end
   end

   // Byte-complete event and address-match wake-up request pulses.
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         event_ff <= 1'b0;
         wake_ff  <= 1'b0;
      end else if (CE_IN) begin
         event_ff <= byte_done;
         wake_ff  <= byte_done && state_ff == iscr_pkg::ST_ADDR && stat_ff.wake_en;
      end
   end

   assign REG_RDATA_OUT  = rdata_ff;
   assign SCL_OUT        = 1'b0;
   assign SDA_OUT        = 1'b0;
   assign SCL_OE_N_OUT   = !scl_hold_ff;
   assign SDA_OE_N_OUT   = !sda_drv_ff;
   assign PIN_FUNC_OUT   = active;
   assign XFER_EVENT_OUT = event_ff;
   assign WAKEUP_OUT     = wake_ff;

   // Checks on the register file and the bus engine.
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN || !CE_IN);

   property p_data_read;
      REG_RD_IN && REG_ADDR_IN == `ISCR_REG_DATA |=> REG_RDATA_OUT == $past(data_ff);
   endproperty
   a_data_read: assert property (p_data_read) else $error("Data read mismatch.");

   property p_addr_store;
      REG_WR_IN && REG_ADDR_IN == `ISCR_REG_ADDR
         ##1 !(REG_WR_IN && REG_ADDR_IN == `ISCR_REG_ADDR)
         ##1 REG_RD_IN && REG_ADDR_IN == `ISCR_REG_ADDR
         |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3);
   endproperty
   a_addr_store: assert property (p_addr_store) else $error("Own address not kept.");

   property p_match;
      state_ff == iscr_pkg::ST_ADDR && byte_end && addr_match
         |=> stat_ff.address_match_flag && !SDA_OE_N_OUT && stat_ff.transfer_complete_flag;
   endproperty
   a_match: assert property (p_match) else $error("Address match not answered.");

   property p_nomatch;
      state_ff == iscr_pkg::ST_ADDR && byte_end && !addr_match |=> !stat_ff.address_match_flag ##1 SDA_OE_N_OUT;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("Mismatch flagged as match.");

   property p_busy;
      (evt.start && !en_rise |=> stat_ff.busy) and (evt.stop && !en_rise |=> !stat_ff.busy);
   endproperty
   a_busy: assert property (p_busy) else $error("Busy flag wrong.");

   property p_rx_ack;
      state_ff == iscr_pkg::ST_RX && byte_end |=> SDA_OE_N_OUT == $past(stat_ff.transmit_ack_bit);
   endproperty
   a_rx_ack: assert property (p_rx_ack) else $error("Ninth-bit ack wrong.");

   property p_en_rise;
      en_rise && !(REG_WR_IN && REG_ADDR_IN == `ISCR_REG_STAT)
         |=> stat_ff.transfer_complete_flag && !stat_ff.address_match_flag && !stat_ff.busy && !stat_ff.master_read_write_flag && stat_ff.receive_ack_flag
         && stat_ff.dir == $past(stat_ff.dir) && stat_ff.transmit_ack_bit == $past(stat_ff.transmit_ack_bit);
   endproperty
   a_en_rise: assert property (p_en_rise) else $error("Enable rise flags wrong.");

   property p_disabled;
      !active && !(REG_WR_IN && REG_ADDR_IN == `ISCR_REG_MODE)
         |=> SDA_OE_N_OUT && SCL_OE_N_OUT && !PIN_FUNC_OUT;
   endproperty
   a_disabled: assert property (p_disabled) else $error("Pins driven while off.");

   property p_mode_bit4;
      REG_RD_IN && REG_ADDR_IN == `ISCR_REG_MODE |=> REG_RDATA_OUT[4] == 1'b0;
   endproperty
   a_mode_bit4: assert property (p_mode_bit4) else $error("Mode bit 4 not zero.");

   property p_tx_release;
      state_ff == iscr_pkg::ST_TX_ACK && evt.fall && stat_ff.receive_ack_flag && !evt.start && !evt.stop
         |=> SDA_OE_N_OUT [*2];
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("SDA held after no-ack.");

   property p_wake;
      byte_done && state_ff == iscr_pkg::ST_ADDR && stat_ff.wake_en |=> WAKEUP_OUT;
   endproperty
   a_wake: assert property (p_wake) else $error("No wake-up on match.");

   property p_debounce;
      mode_ff.deb == `ISCR_DEB_SEL_SHORT && $changed(scl_filt_ff)
         |-> $past(scl_lvl_ff) == scl_filt_ff && $past(scl_lvl_ff, 2) == scl_filt_ff;
   endproperty
   a_debounce: assert property (p_debounce) else $error("SCL accepted too early.");

endmodule

// *** tb/iscr_bus_master.sv ***
`timescale 1ns/10ps
// Behavioural two-wire bus master; lines are open drain, released lines float high.
module iscr_bus_master (
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_oe_n_out,
   output logic      sda_oe_n_out
);
   // One bus phase is three 64 ns link periods, above the 20-clock minimum phase.
   localparam int PH = 192;

   // Both lines start released.
   initial begin
      scl_oe_n_out = 1'b1;
      sda_oe_n_out = 1'b1;
   end

   // Releases the clock line and waits out any clock hold by the slave.
   task automatic scl_high();
      scl_oe_n_out = 1'b1;
      while (scl_in !== 1'b1) #8;
      #PH;
   endtask

   // Puts one bit out while the clock is low and samples the line before the fall.
   task automatic bit_io(input logic b, output logic r);
      sda_oe_n_out = b;
      #PH;
      scl_high();
      r = sda_in;
      scl_oe_n_out = 1'b0;
   endtask

   // Data falls while the clock stays high.
   task automatic start_cond();
      sda_oe_n_out = 1'b1;
      #3.3;
      scl_high();
      sda_oe_n_out = 1'b0;
      #PH;
      scl_oe_n_out = 1'b0;
   endtask

   // Data rises while the clock stays high.
   task automatic stop_cond();
      sda_oe_n_out = 1'b0;
      #PH;
      scl_high();
      sda_oe_n_out = 1'b1;
      #PH;
   endtask

   // Sends eight bits, most significant first, and returns the ninth-bit level.
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, ack);
      // Lets the slave see the ninth fall and hold the clock before software answers.
      #PH;
   endtask

   // Reads eight bits and answers with the given acknowledge level.
   task automatic recv_byte(input logic nack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(nack, r);
      #PH;
   endtask
endmodule

// *** tb/iscr_tb_top.sv ***
`timescale 1ns/10ps
`include "iscr_defines.svh"
module iscr_tb_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] ra = 2'h0;
   logic [7:0] wd = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] rdata;
   logic       scl_d, sda_d, scl_m, sda_m, pin, ev, wk, ack;
   logic [7:0] d;
   int         bad_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         ev_cnt = 0;
   int         wk_cnt = 0;
   // Pull-ups: a line is low only while some party pulls it.
   wire        scl = scl_d & scl_m;
   wire        sda = sda_d & sda_m;
   // Rows: address, write data, read back, pin function.
   localparam logic [18:0] ROWS [13] = '{
      {2'h0, 8'h3C, 8'h3C, 1'h0}, {2'h1, 8'hA5, 8'hA5, 1'h0}, {2'h3, 8'hFF, 8'h9B, 1'h0},
      {2'h3, 8'h00, 8'h81, 1'h0}, {2'h2, 8'h02, 8'h02, 1'h0}, {2'h2, 8'h22, 8'h22, 1'h0},
      {2'h2, 8'h42, 8'h42, 1'h0}, {2'h2, 8'h62, 8'h62, 1'h0}, {2'h2, 8'h82, 8'h82, 1'h0},
      {2'h2, 8'hA2, 8'hA2, 1'h0}, {2'h2, 8'hC2, 8'hC2, 1'h1}, {2'h2, 8'hE2, 8'hE2, 1'h0},
      {2'h2, 8'hFF, 8'hEF, 1'h0}};

   iscr_top iscr_top_i (
      .CLK_IN(clk), .RESET_IN(rst), .CE_IN(1'b1), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
      .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .SCL_IN(scl),
      .SCL_OUT(), .SCL_OE_N_OUT(scl_d), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N_OUT(sda_d),
      .PIN_FUNC_OUT(pin), .XFER_EVENT_OUT(ev), .WAKEUP_OUT(wk));

   iscr_bus_master iscr_bus_master_i (
      .scl_in(scl), .sda_in(sda), .scl_oe_n_out(scl_m), .sda_oe_n_out(sda_m));

   // System clock at 125 MHz.
   always #4 clk = ~clk;

   // Counts pulses and cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (ev === 1'b1) ev_cnt++;
      if (wk === 1'b1) wk_cnt++;
      if (cyc == 50000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      ra <= a;
      wd <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // Reads a register and compares the masked value.
   task automatic rdc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence: reset values first, then the table and the bus transfers.
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdc(`ISCR_REG_DATA, 8'hFF, `ISCR_DATA_RST);
      rdc(`ISCR_REG_ADDR, 8'hFF, `ISCR_ADDR_RST);
      rdc(`ISCR_REG_MODE, 8'hFF, `ISCR_MODE_RST);
      rdc(`ISCR_REG_STAT, 8'hFF, `ISCR_STAT_RST);
      chk({6'h00, scl_d, sda_d}, 8'h03);
      done("reset");
      for (int k = 0; k < 13; k++) begin
         wr(ROWS[k][18:17], ROWS[k][16:9]);
         rdc(ROWS[k][18:17], 8'hFF, ROWS[k][8:1]);
         chk({7'h00, pin}, {7'h00, ROWS[k][0]});
      end
      done("table");
      wr(`ISCR_REG_MODE, 8'hC2);
      wr(`ISCR_REG_ADDR, 8'hB5);
      iscr_bus_master_i.start_cond();
      rdc(`ISCR_REG_STAT, 8'hA0, 8'h20);
      iscr_bus_master_i.send_byte(8'hB4, ack);
      chk({7'h00, ack}, 8'h00);
      rdc(`ISCR_REG_STAT, 8'hFF, 8'hE1);
      rdc(`ISCR_REG_DATA, 8'h00, 8'h00);
      iscr_bus_master_i.send_byte(8'hC3, ack);
      chk({7'h00, ack}, 8'h00);
      wr(`ISCR_REG_STAT, 8'h08);
      rdc(`ISCR_REG_DATA, 8'hFF, 8'hC3);
      iscr_bus_master_i.send_byte(8'h5E, ack);
      chk({7'h00, ack}, 8'h01);
      wr(`ISCR_REG_STAT, 8'h00);
      rdc(`ISCR_REG_DATA, 8'hFF, 8'h5E);
      iscr_bus_master_i.stop_cond();
      rdc(`ISCR_REG_STAT, 8'h20, 8'h00);
      done("slave receive");
      wr(`ISCR_REG_MODE, 8'hC6);
      wr(`ISCR_REG_STAT, 8'h02);
      iscr_bus_master_i.start_cond();
      iscr_bus_master_i.send_byte(8'hB5, ack);
      chk({7'h00, ack}, 8'h00);
      chk(8'(wk_cnt), 8'h01);
      rdc(`ISCR_REG_STAT, 8'h44, 8'h44);
      wr(`ISCR_REG_STAT, 8'h10);
      wr(`ISCR_REG_DATA, 8'hA6);
      iscr_bus_master_i.recv_byte(1'b0, d);
      chk(d, 8'hA6);
      rdc(`ISCR_REG_STAT, 8'h01, 8'h00);
      wr(`ISCR_REG_DATA, 8'h71);
      iscr_bus_master_i.recv_byte(1'b1, d);
      chk(d, 8'h71);
      rdc(`ISCR_REG_STAT, 8'h01, 8'h01);
      chk({7'h00, sda_d}, 8'h01);
      iscr_bus_master_i.stop_cond();
      done("slave transmit");
      wr(`ISCR_REG_MODE, 8'hC4);
      #1;
      chk({6'h00, pin, sda_d}, 8'h01);
      wr(`ISCR_REG_STAT, 8'h18);
      wr(`ISCR_REG_MODE, 8'hC6);
      rdc(`ISCR_REG_STAT, 8'hFF, 8'h99);
      done("enable rise");
      wr(`ISCR_REG_MODE, 8'hCA);
      wr(`ISCR_REG_STAT, 8'h00);
      iscr_bus_master_i.start_cond();
      iscr_bus_master_i.send_byte(8'hB6, ack);
      chk({7'h00, ack}, 8'h01);
      rdc(`ISCR_REG_STAT, 8'h60, 8'h20);
      iscr_bus_master_i.stop_cond();
      rdc(`ISCR_REG_STAT, 8'h20, 8'h00);
      chk(8'(ev_cnt), 8'h06);
      done("no match");
      finish_test();
   end
endmodule
